// >>> bench/slw_link_model.sv
`timescale 1ns/10ps
module slw_link_model
    import slw_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       pwr,
    input  wire logic       wiggle,
    input  wire logic [3:0] code,
    output logic      [3:0] lts
);
    logic [5:0] cnt = 6'h00;
    always @(posedge clk) begin
        cnt <= cnt + 6'h01;
    end
    // unpowered device: the port only ever sees receiver detect
    always_comb begin
        lts = !pwr ? LTS_DISABLED + 4'h1
            : (wiggle && cnt[5]) ? code + 4'h1 : code;
    end
endmodule : slw_link_model

// >>> bench/slw_top_checker.sv
`timescale 1ns/10ps
module slw_top_checker
    import slw_pkg::*;
#(
    parameter int unsigned TICK_CYCLES_P = 4
) (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        reg_rd_en,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0]  reg_rdata,
    input wire logic [3:0]  link_training_state_status_p4,
    input wire logic [3:0]  link_training_state_status_p5,
    input wire logic        superspeed_half_power_pin_p4,
    input wire logic        superspeed_half_power_pin_p5
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire logic       p4 = superspeed_half_power_pin_p4;
    wire logic       p5 = superspeed_half_power_pin_p5;
    wire logic [3:0] l4 = link_training_state_status_p4;
    wire logic [3:0] l5 = link_training_state_status_p5;
    // low time outlives any delay range, so count it
    logic [15:0]     low_cnt;
    logic [15:0]     next_low_cnt;
    always_comb begin
        next_low_cnt = p4 ? 16'h0000 : low_cnt + 16'h0001;
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            low_cnt <= 16'h0000;
        end else begin
            low_cnt <= next_low_cnt;
        end
    end
    a_rdata_idle_zero: assert property (
        !reg_rd_en |=> reg_rdata == 8'h00)
        else $error("read data not zero when idle");
    a_sel_resv_zero: assert property (
        reg_rd_en && reg_addr == ADDR_TIMEOUT_SEL
        |=> reg_rdata[7:3] == 5'h00)
        else $error("timeout reserved bits set");
    a_glob_resv_zero: assert property (
        reg_rd_en && reg_addr == ADDR_GLOBAL_SPLIT
        |=> reg_rdata[7:1] == 7'h00)
        else $error("global reserved bits set");
    a_p4_stuck_cause: assert property (
        $fell(p4) |-> $past(l4) inside {[LTS_DISABLED:LTS_HOT_RESET]})
        else $error("port4 pulse without stuck state");
    a_p5_stuck_cause: assert property (
        $fell(p5) |-> $past(l5) inside {[LTS_DISABLED:LTS_HOT_RESET]})
        else $error("port5 pulse without stuck state");
    a_p4_state_held: assert property (
        $fell(p4) |-> $past(l4, 8) == $past(l4))
        else $error("port4 pulse after state change");
    a_p4_restart_gap: assert property (
        $rose(p4) |=> p4 [*8])
        else $error("port4 pulse right after previous");
    a_p5_restart_gap: assert property (
        $rose(p5) |=> p5 [*8])
        else $error("port5 pulse right after previous");
    a_pulse_max_len: assert property (
        low_cnt <= 2901 * TICK_CYCLES_P)
        else $error("port4 pulse too long");
    a_reset_pins_high: assert property (
        disable iff (1'b0) !arst_n |-> p4 && p5)
        else $error("pins low in reset");
    c_p4_pulse: cover property ($fell(p4));
    c_p5_pulse: cover property ($fell(p5));
    c_sel_read: cover property (reg_rd_en && reg_addr == ADDR_TIMEOUT_SEL);
endmodule : slw_top_checker

// >>> bench/slw_top_tb.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("FAIL %s exp %0h got %0h", n, e, g); end end
module slw_top_tb;
    import slw_pkg::*;
    localparam int TK = 4;
    logic        clk = 1'b0, arst_n = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
    logic        ol = 1'b0, ov = 1'b0, wig = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wd = 8'h00;
    logic [2:0]  os = 3'h0;
    logic [3:0]  code = 4'h0;
    logic [7:0]  rdata;
    logic [3:0]  l4, l5;
    logic        p4, p5;
    int          compares = 0, miscompares = 0, cyc = 0, n, t, pl;
    int          tmo[6] = '{100, 250, 750, 1000, 1000, 2000};
    slw_top #(.TICK_CYCLES_P(TK)) slw_top_i (.clk(clk), .arst_n(arst_n),
        .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
        .reg_wdata(wd), .reg_rdata(rdata), .otp_load(ol),
        .otp_timeout_valid(ov), .otp_timeout_sel(os),
        .link_training_state_status_p4(l4), .link_training_state_status_p5(l5),
        .superspeed_half_power_pin_p4(p4), .superspeed_half_power_pin_p5(p5));
    slw_link_model slw_link_model_i [1:0] (.clk(clk), .pwr({p5, p4}),
        .wiggle(wig), .code(code), .lts({l5, l4}));
    initial forever #25 clk = ~clk;
    task automatic tally_and_finish;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk); wr_en <= 1'b1; addr <= a; wd <= d;
        @(posedge clk); wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk); rd_en <= 1'b1; addr <= a;
        @(posedge clk); rd_en <= 1'b0;
        #1;
        `CHK($sformatf("reg %h", a), e, rdata)
    endtask : rd
    // bounded wait for port4 pin level, cycles in c
    task automatic wait_p4(input logic lv, input int mx, output int c);
        c = 0;
        while (p4 !== lv && c < mx) begin
            @(posedge clk); #1; c++;
        end
    endtask : wait_p4
    initial begin
        // a real falling edge, so the pins are reset before the first clock
        arst_n <= 1'b0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        rd(ADDR_SPLIT_EN, 8'h00); rd(ADDR_GLOBAL_SPLIT, 8'h00);
        rd(ADDR_TIMEOUT_SEL, 8'h05); rd(ADDR_PULSE_LEN, 8'h05);
        rd(ADDR_STATUS, 8'h00); rd(16'h0000, 8'h00);
        wr(ADDR_TIMEOUT_SEL, 8'hFF); rd(ADDR_TIMEOUT_SEL, 8'h07);
        wr(ADDR_GLOBAL_SPLIT, 8'hFF); rd(ADDR_GLOBAL_SPLIT, 8'h01);
        wr(ADDR_SPLIT_EN, 8'hFF); rd(ADDR_SPLIT_EN, 8'hFE);
        wr(ADDR_STATUS, 8'hFF); rd(ADDR_STATUS, 8'h00);
        @(posedge clk); ol <= 1'b1; ov <= 1'b1; os <= 3'h2;
        @(posedge clk); ol <= 1'b0; ov <= 1'b0;
        rd(ADDR_TIMEOUT_SEL, 8'h02);
        @(posedge clk); ol <= 1'b1; os <= 3'h6;
        @(posedge clk); ol <= 1'b0;
        rd(ADDR_TIMEOUT_SEL, 8'h02);
        // port4 only; changing states must keep the timer from expiring
        @(posedge clk); code <= 4'h5; wig <= 1'b1;
        wr(ADDR_SPLIT_EN, 8'h20); wr(ADDR_PULSE_LEN, 8'h00);
        wr(ADDR_TIMEOUT_SEL, 8'h01);
        repeat (1000) @(posedge clk);
        #1 `CHK("p4 wiggling", 1'b1, p4)
        // fresh code restarts the timer whatever phase the wiggle had
        @(posedge clk); code <= 4'h7; wig <= 1'b0;
        wait_p4(1'b0, 600, n);
        `CHK($sformatf("first %0d", n), 1'b1, n >= 392 && n <= 408)
        `CHK("p5 disabled", 1'b1, p5)
        wait_p4(1'b1, 2000, n);
        wait_p4(1'b0, 600, n);
        `CHK($sformatf("gap %0d", n), 1'b1, n >= 392 && n <= 408)
        wait_p4(1'b1, 2000, n);
        wr(ADDR_TIMEOUT_SEL, 8'h00);
        wait_p4(1'b0, 3000, n);
        `CHK("no pulse", 3000, n)
        // codes outside the stuck set never expire
        @(posedge clk); code <= 4'h3;
        wr(ADDR_TIMEOUT_SEL, 8'h01);
        wait_p4(1'b0, 600, n);
        `CHK("code 3", 600, n)
        @(posedge clk); code <= 4'hA;
        wait_p4(1'b0, 600, n);
        `CHK("code A", 600, n)
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_GLOBAL_SPLIT, 8'h00);
            @(posedge clk); code <= 4'(4 + i);
            pl = (i == 5) ? 255 : i;
            wr(ADDR_SPLIT_EN, 8'h60); wr(ADDR_PULSE_LEN, 8'(pl));
            wr(ADDR_TIMEOUT_SEL, 8'(i + 1));
            wr(ADDR_GLOBAL_SPLIT, 8'h01);
            t = tmo[i] * TK;
            wait_p4(1'b0, t + 40, n);
            `CHK($sformatf("tmo %0d", n), 1'b1, n >= t - 8 && n <= t + 8)
            `CHK("p5 pulse", 1'b0, p5)
            rd(ADDR_STATUS, 8'h03);
            t = (350 + 10 * pl) * TK;
            wait_p4(1'b1, t + 40, n);
            `CHK($sformatf("len %0d", n), 1'b1, n >= t - 4 && n <= t + 4)
        end
        // pulse stops as soon as the function goes away
        wr(ADDR_TIMEOUT_SEL, 8'h01);
        wait_p4(1'b0, 600, n);
        `CHK("p4 low", 1'b0, p4)
        wr(ADDR_GLOBAL_SPLIT, 8'h00);
        @(posedge clk); #1 `CHK("p4 abort", 1'b1, p4)
        `CHK("p5 abort", 1'b1, p5)
        // reset in mid-pulse releases the pins and restores defaults
        wr(ADDR_GLOBAL_SPLIT, 8'h01);
        wait_p4(1'b0, 600, n);
        @(posedge clk); arst_n <= 1'b0;
        @(posedge clk); #1 `CHK("p4 reset", 1'b1, p4)
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        rd(ADDR_TIMEOUT_SEL, 8'h05);
        rd(ADDR_PULSE_LEN, 8'h05);
        tally_and_finish();
    end
endmodule : slw_top_tb
bind slw_top slw_top_checker #(.TICK_CYCLES_P(TICK_CYCLES_P))
    slw_top_checker_i (
    .clk(clk), .arst_n(arst_n), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata),
    .link_training_state_status_p4(link_training_state_status_p4),
    .link_training_state_status_p5(link_training_state_status_p5),
    .superspeed_half_power_pin_p4(superspeed_half_power_pin_p4),
    .superspeed_half_power_pin_p5(superspeed_half_power_pin_p5));

// >>> common/slw_pkg.sv
package slw_pkg;
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned TICK_PERIOD_MS  = 1;
    localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_PERIOD_MS;
    localparam int          TICK_W          = 15;
    localparam int          MS_W            = 12;

    localparam logic [15:0] ADDR_SPLIT_EN     = 16'h3C48;
    localparam logic [15:0] ADDR_GLOBAL_SPLIT = 16'h4141;
    localparam logic [15:0] ADDR_TIMEOUT_SEL  = 16'h4171;
    localparam logic [15:0] ADDR_PULSE_LEN    = 16'h4176;
    localparam logic [15:0] ADDR_STATUS       = 16'h4177;

    localparam logic [7:0]  RST_SPLIT_EN      = 8'h00;
    localparam logic [7:0]  RST_GLOBAL_SPLIT  = 8'h00;
    localparam logic [2:0]  RST_TIMEOUT_SEL   = 3'h5;
    localparam logic [7:0]  RST_PULSE_LEN     = 8'h05;

    localparam int          SPLIT_EN_P4_BIT   = 5;
    localparam int          SPLIT_EN_P5_BIT   = 6;
    localparam int          GLOBAL_SPLIT_BIT  = 0;

    localparam logic [3:0]  LTS_DISABLED      = 4'h4;
    localparam logic [3:0]  LTS_HOT_RESET     = 4'h9;

    localparam logic [MS_W-1:0] TIMEOUT_100MS = 12'd100;
    localparam logic [MS_W-1:0] TIMEOUT_250MS = 12'd250;
    localparam logic [MS_W-1:0] TIMEOUT_750MS = 12'd750;
    localparam logic [MS_W-1:0] TIMEOUT_1S    = 12'd1000;
    localparam logic [MS_W-1:0] TIMEOUT_2S    = 12'd2000;
    localparam logic [MS_W-1:0] PULSE_BASE_MS = 12'd350;
    localparam logic [MS_W-1:0] PULSE_STEP_MS = 12'd10;

    typedef enum logic [0:0] {
        SLW_WATCH = 1'b0,
        SLW_PULSE = 1'b1
    } slw_state_t;

    function automatic logic [MS_W-1:0] slw_timeout_ms(
        input logic [2:0] sel
    );
        unique case (sel)
            3'h1:    slw_timeout_ms = TIMEOUT_100MS;
            3'h2:    slw_timeout_ms = TIMEOUT_250MS;
            3'h3:    slw_timeout_ms = TIMEOUT_750MS;
            3'h4:    slw_timeout_ms = TIMEOUT_1S;
            3'h5:    slw_timeout_ms = TIMEOUT_1S;
            3'h6:    slw_timeout_ms = TIMEOUT_2S;
            default: slw_timeout_ms = '0;
        endcase
    endfunction : slw_timeout_ms

    function automatic logic slw_is_stuck(input logic [3:0] lts);
        slw_is_stuck = (lts >= LTS_DISABLED) && (lts <= LTS_HOT_RESET);
    endfunction : slw_is_stuck
endpackage : slw_pkg

// >>> rtl/slw_port.sv
`timescale 1ns/10ps
module slw_port
    import slw_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            arst_n,
    input  wire logic            tick,
    input  wire logic            enable,
    input  wire logic [MS_W-1:0] timeout_ms,
    input  wire logic [MS_W-1:0] pulse_ms,
    input  wire logic [3:0]      link_training_state_status,
    output logic                 superspeed_half_power_pin,
    output logic                 pulsing
);
    slw_state_t      state;
    slw_state_t      next_state;
    logic [MS_W-1:0] timer;
    logic [MS_W-1:0] next_timer;
    logic [3:0]      last_lts;
    logic            next_pin;

    always_comb begin
        next_state = state;
        next_timer = timer;
        next_pin   = 1'b1;
        unique case (state)
            SLW_WATCH: begin
                // change or valid state restarts the wait
                if (!enable || !slw_is_stuck(link_training_state_status) ||
                    link_training_state_status != last_lts) begin
                    next_timer = '0;
                end else if (tick) begin
                    next_timer = timer + 1'b1;
                    if (next_timer >= timeout_ms) begin
                        next_state = SLW_PULSE;
                        next_timer = '0;
                        next_pin   = 1'b0;
                    end
                end
            end
            SLW_PULSE: begin
                next_pin = 1'b0;
                // dropping the enable aborts the pulse
                if (!enable) begin
                    next_state = SLW_WATCH;
                    next_timer = '0;
                    next_pin   = 1'b1;
                end else if (tick) begin
                    next_timer = timer + 1'b1;
                    if (next_timer >= pulse_ms) begin
                        next_state = SLW_WATCH;
                        next_timer = '0;
                        next_pin   = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state                     <= SLW_WATCH;
            timer                     <= '0;
            last_lts                  <= 4'h0;
            superspeed_half_power_pin <= 1'b1;
            pulsing                   <= 1'b0;
        end else begin
            state                     <= next_state;
            timer                     <= next_timer;
            last_lts                  <= link_training_state_status;
            superspeed_half_power_pin <= next_pin;
            pulsing                   <= (next_state == SLW_PULSE);
        end
    end
endmodule : slw_port

// >>> rtl/slw_tick.sv
`timescale 1ns/10ps
module slw_tick
    import slw_pkg::*;
#(
    parameter int unsigned CYCLES = TICK_CYCLES
) (
    input  wire logic clk,
    input  wire logic arst_n,
    output logic      tick
);
    logic [TICK_W-1:0] count;
    logic [TICK_W-1:0] next_count;
    logic              next_tick;

    always_comb begin
        next_tick  = 1'b0;
        next_count = count + 1'b1;
        if (count == TICK_W'(CYCLES - 1)) begin
            next_count = '0;
            next_tick  = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= '0;
            tick  <= 1'b0;
        end else begin
            count <= next_count;
            tick  <= next_tick;
        end
    end
endmodule : slw_tick

// >>> rtl/slw_top.sv
`timescale 1ns/10ps
// Behaviour
// - with split on, watch the link; no valid link for timeout pulses pin.
// - each expiry clears and restarts the timer; stuck link repeats pulses.
// - stuck means training state held in 0x4..0x9 for the whole timeout.
// - timeout field zero disables the function; pin never pulses.
// - timeout register resets to 0x05, meaning one second.
// - 3-bit field picks 100ms, 250ms, 750ms, 1s, 2s; all-ones reserved.
// - timeout is register programmable and can be overridden by OTP.
// - pulse low time is 350 ms plus 10 ms per toggle-time count.
// - toggle time resets for 400 ms; range 350 ms to 2.9 s.
// - pulse timer clears when each pulse ends.
// - toggle time drives only the split pin, only with timeout function.
// - split only on ports four and five, per-port plus global enable.
// - split pin controls only the superspeed half; no overcurrent sensing.
module slw_top
    import slw_pkg::*;
#(
    parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        reg_wr_en,
    input  wire logic        reg_rd_en,
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic        otp_load,
    input  wire logic        otp_timeout_valid,
    input  wire logic [2:0]  otp_timeout_sel,
    input  wire logic [3:0]  link_training_state_status_p4,
    input  wire logic [3:0]  link_training_state_status_p5,
    output logic             superspeed_half_power_pin_p4,
    output logic             superspeed_half_power_pin_p5
);
    logic [7:1]      per_port_separation_enable;
    logic            global_split_enable;
    logic [2:0]      split_link_timeout_select;
    logic [7:0]      split_reset_pulse_length;
    logic [7:1]      next_port_en;
    logic            next_global;
    logic [2:0]      next_timeout_sel;
    logic [7:0]      next_pulse_len;
    logic [7:0]      next_rdata;
    logic            tick;
    logic [MS_W-1:0] timeout_ms;
    logic [MS_W-1:0] pulse_ms;
    logic            func_on;
    logic            en_p4;
    logic            en_p5;
    logic            pulsing_p4;
    logic            pulsing_p5;

    // registers and OTP override
    always_comb begin
        next_port_en     = per_port_separation_enable;
        next_global      = global_split_enable;
        next_timeout_sel = split_link_timeout_select;
        next_pulse_len   = split_reset_pulse_length;
        if (reg_wr_en) begin
            unique case (reg_addr)
                ADDR_SPLIT_EN:     next_port_en   = reg_wdata[7:1];
                ADDR_GLOBAL_SPLIT: next_global    = reg_wdata[GLOBAL_SPLIT_BIT];
                ADDR_TIMEOUT_SEL:  next_timeout_sel = reg_wdata[2:0];
                ADDR_PULSE_LEN:    next_pulse_len = reg_wdata;
                default: ;
            endcase
        end
        // otp wins over a same-cycle bus write to keep the strap authoritative
        if (otp_load && otp_timeout_valid) begin
            next_timeout_sel = otp_timeout_sel;
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd_en) begin
            unique case (reg_addr)
                ADDR_SPLIT_EN:     next_rdata = {per_port_separation_enable,
                                                 1'b0};
                ADDR_GLOBAL_SPLIT: next_rdata = {7'h00, global_split_enable};
                ADDR_TIMEOUT_SEL:  next_rdata = {5'h00,
                                                 split_link_timeout_select};
                ADDR_PULSE_LEN:    next_rdata = split_reset_pulse_length;
                ADDR_STATUS:       next_rdata = {6'h00, pulsing_p5,
                                                 pulsing_p4};
                default:           next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            per_port_separation_enable <= RST_SPLIT_EN[7:1];
            global_split_enable        <= RST_GLOBAL_SPLIT[0];
            split_link_timeout_select  <= RST_TIMEOUT_SEL;
            split_reset_pulse_length   <= RST_PULSE_LEN;
            reg_rdata                  <= 8'h00;
        end else begin
            per_port_separation_enable <= next_port_en;
            global_split_enable        <= next_global;
            split_link_timeout_select  <= next_timeout_sel;
            split_reset_pulse_length   <= next_pulse_len;
            reg_rdata                  <= next_rdata;
        end
    end

    // reserved code maps to zero, so it also disables
    assign timeout_ms = slw_timeout_ms(split_link_timeout_select);
    assign func_on    = (timeout_ms != '0);
    // max 350 + 2550 = 2900 ms fits the 12-bit timer
    assign pulse_ms   = PULSE_BASE_MS + MS_W'(split_reset_pulse_length) *
                        PULSE_STEP_MS;
    // only ports four and five can split
    assign en_p4 = func_on && global_split_enable &&
                   per_port_separation_enable[SPLIT_EN_P4_BIT];
    assign en_p5 = func_on && global_split_enable &&
                   per_port_separation_enable[SPLIT_EN_P5_BIT];

    // 1 ms grain: timeouts run up to one tick short of nominal
    slw_tick #(
        .CYCLES (TICK_CYCLES_P)
    ) u_tick (
        .clk    (clk),
        .arst_n (arst_n),
        .tick   (tick)
    );

    // pins are plain power enables, no overcurrent input
    slw_port u_port4 (
        .clk                        (clk),
        .arst_n                     (arst_n),
        .tick                       (tick),
        .enable                     (en_p4),
        .timeout_ms                 (timeout_ms),
        .pulse_ms                   (pulse_ms),
        .link_training_state_status (link_training_state_status_p4),
        .superspeed_half_power_pin  (superspeed_half_power_pin_p4),
        .pulsing                    (pulsing_p4)
    );

    slw_port u_port5 (
        .clk                        (clk),
        .arst_n                     (arst_n),
        .tick                       (tick),
        .enable                     (en_p5),
        .timeout_ms                 (timeout_ms),
        .pulse_ms                   (pulse_ms),
        .link_training_state_status (link_training_state_status_p5),
        .superspeed_half_power_pin  (superspeed_half_power_pin_p5),
        .pulsing                    (pulsing_p5)
    );
endmodule : slw_top
